//--- verilog/wtc_pkg.sv
package wtc_pkg;

    // ------------------------------------------------------------------
    // Register map and bus widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W            = 8;         // Register address width.
    localparam int unsigned DATA_W            = 8;         // Register data width.
    localparam logic [7:0]  OFS_WDOG_CONTROL  = 8'h00;     // Watchdog control register.
    localparam logic [7:0]  OFS_CORE_STATUS   = 8'h01;     // Core status flags, read only.
    localparam logic [7:0]  OFS_POWER_CONTROL = 8'h02;     // Power control register.

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTL_SWEN_BIT      = 0;         // Soft watchdog enable bit.
    localparam int unsigned CTL_PS_LSB        = 1;         // Prescale select low bit.
    localparam int unsigned CTL_PS_MSB        = 5;         // Prescale select high bit.
    localparam int unsigned STS_TIMEOUT_BIT   = 4;         // Time-out flag, low after a time-out.
    localparam int unsigned STS_POWERDOWN_BIT = 3;         // Power-down flag, low after sleep entry.
    localparam int unsigned POWER_CONTROL_REG_WRST_BIT     = 4;         // Watchdog reset flag, low after a reset.

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [4:0]  PS_RESET          = 5'h0b;     // 2048 ms, nominal 2 seconds.
    localparam logic        SWEN_RESET        = 1'b0;      // Soft enable off after reset.

    // ------------------------------------------------------------------
    // Mode encodings of the configuration field
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_OFF          = 2'h0;      // Always disabled.
    localparam logic [1:0]  MODE_SOFT         = 2'h1;      // Controlled by soft enable.
    localparam logic [1:0]  MODE_NO_SLEEP     = 2'h2;      // On except in sleep.
    localparam logic [1:0]  MODE_ALWAYS       = 2'h3;      // Always on.

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 125_000_000; // System clock rate.
    localparam int unsigned OSC_HZ            = 31_000;      // Low frequency oscillator rate.
    localparam int unsigned TICK_MS           = 1;           // Base interval in ms.
    localparam int unsigned OSC_EDGES_PER_TICK = OSC_HZ * TICK_MS / 1000; // Oscillator edges per tick.
    localparam int unsigned EDGE_CNT_W        = 5;           // Width of the edge counter.
    localparam int unsigned MS_CNT_W          = 19;          // Millisecond counter width.
    localparam logic [4:0]  PS_MAX_CODE       = 5'h12;       // Code 18 gives 262144 ms, nominal 256 s.

    // Device state as seen by the watchdog, Gray coded along awake-sleep-waking.
    typedef enum logic [1:0] {
        ST_AWAKE  = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_WAKING = 2'b11
    } wtc_state_t;

endpackage : wtc_pkg

//--- verilog/wtc_tick_gen.sv
module wtc_tick_gen (
    input  wire logic clk,        // System clock.
    input  wire logic rst,        // Synchronous reset, active high.
    input  wire logic oscLevel,   // Level of the low frequency oscillator.
    input  wire logic clearPhase, // Restarts the tick phase.
    output logic      tick        // One-cycle pulse per base interval.
);
    import wtc_pkg::*;

    // ------------------------------------------------------------------
    // Edge detection and division
    // ------------------------------------------------------------------
    logic                  oscPrev;   // Oscillator level one cycle ago.
    logic [EDGE_CNT_W-1:0] edgeCount; // Rising edges seen in this interval.
    logic                  oscRise;   // Rising edge of the oscillator.

    assign oscRise = oscLevel & ~oscPrev;

    // Remembers the previous oscillator level.
    always_ff @(posedge clk) begin
        if (rst) begin
            oscPrev <= 1'b0;
        end else begin
            oscPrev <= oscLevel;
        end
    end

    // Counts oscillator edges and pulses the tick once per interval.
    always_ff @(posedge clk) begin
        if (rst || clearPhase) begin
            edgeCount <= '0;
            tick      <= 1'b0;
        end else if (oscRise) begin
            if (edgeCount == EDGE_CNT_W'(OSC_EDGES_PER_TICK - 1)) begin
                edgeCount <= '0;
                tick      <= 1'b1;
            end else begin
                edgeCount <= edgeCount + 1'b1;
                tick      <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule : wtc_tick_gen

//--- verilog/wtc_core.sv
// The plain strobed port and the register addresses were left to the implementer.
module wtc_core (
    input  wire logic                       clk,           // System clock, 125 MHz.
    input  wire logic                       rst,           // Synchronous reset, active high.
    input  wire logic                       oscLevel,      // Low frequency oscillator level.
    input  wire logic [1:0]                 modeCfg,       // Watchdog mode configuration field.
    input  wire logic                       sleepActive,   // Core is in sleep.
    input  wire logic                       clearInstr,    // Clear instruction executed, pulse.
    input  wire logic                       oscFail,       // Oscillator failure detected.
    input  wire logic                       oscStartupRun, // Oscillator start-up timer running.
    input  wire logic [wtc_pkg::ADDR_W-1:0] regAddr,       // Register address.
    input  wire logic [wtc_pkg::DATA_W-1:0] regWdata,      // Register write data.
    input  wire logic                       regWr,         // Register write strobe.
    input  wire logic                       regRd,         // Register read strobe.
    output logic      [wtc_pkg::DATA_W-1:0] regRdata,      // Read data, one cycle after strobe.
    output logic                            resetReq,      // Device reset request pulse.
    output logic                            wakeReq,       // Wake request pulse.
    output logic                            wdogActive     // Watchdog currently active.
);
    import wtc_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Decides whether the watchdog runs for a mode and device state.
    function automatic logic modeActive(input logic [1:0] mode, input logic swEn, input logic asleep);
        logic act;
        act = 1'b0;
        case (mode)
            MODE_ALWAYS:   act = 1'b1;
            MODE_NO_SLEEP: act = ~asleep;
            MODE_SOFT:     act = swEn;
            MODE_OFF:      act = 1'b0;
            default:       act = 1'b0;
        endcase
        return act;
    endfunction : modeActive

    // Gives the last millisecond count of a period for a prescale code.
    function automatic logic [MS_CNT_W-1:0] lastCount(input logic [4:0] code);
        logic [4:0]          sel;
        logic [MS_CNT_W-1:0] period;
        sel    = (code > PS_MAX_CODE) ? PS_MAX_CODE : code;
        period = MS_CNT_W'(1) << sel;
        return period - MS_CNT_W'(1);
    endfunction : lastCount

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic                softEnable;    // Soft watchdog enable.
    logic [4:0]          prescaleSel;   // Prescale select.
    logic                timeoutFlagN;  // Low after a watchdog time-out.
    logic                powerdownFlagN;// Low after sleep entry.
    logic                wdogResetFlagN;// Low after a watchdog reset.
    logic [MS_CNT_W-1:0] msCount;       // Elapsed milliseconds.
    logic                sleepPrev;     // Sleep level one cycle ago.
    wtc_state_t          devState;      // Device state tracker.
    wtc_state_t          next_devState; // Next device state.
    logic                tick;          // Base interval pulse.
    logic                sleepEdge;     // Sleep entered or left.
    logic                sleepEnter;    // Sleep entered.
    logic                clearCount;    // Counter clear condition.
    logic                timeout;       // Time-out in this cycle.
    logic                wrCtl;         // Write to control register.
    logic                wrPcon;        // Write to power control register.

    assign sleepEdge  = sleepActive ^ sleepPrev;
    assign sleepEnter = sleepActive & ~sleepPrev;
    assign wrCtl      = regWr && (regAddr == OFS_WDOG_CONTROL);
    assign wrPcon     = regWr && (regAddr == OFS_POWER_CONTROL);

    // Watchdog is active per mode, soft enable and the sleep level.
    assign wdogActive = modeActive(modeCfg, softEnable, sleepActive);

    // Time-out on the tick that ends the selected period.
    assign timeout = wdogActive && tick && (msCount == lastCount(prescaleSel)) && !clearCount;

    // Every condition other than reset and a time-out that forces the counter to zero.
    assign clearCount = clearInstr
                      | sleepEdge
                      | oscFail | ~wdogActive | oscStartupRun
                      | (devState == ST_WAKING);

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    wtc_tick_gen u_tick (
        .clk        (clk),
        .rst        (rst),
        .oscLevel   (oscLevel),
        .clearPhase (clearCount),
        .tick       (tick)
    );

    // ------------------------------------------------------------------
    // Device state tracking
    // ------------------------------------------------------------------

    // Remembers the sleep level for edge detection.
    always_ff @(posedge clk) begin
        if (rst) begin
            sleepPrev <= 1'b0;
        end else begin
            sleepPrev <= sleepActive;
        end
    end

    // Chooses the next device state from the sleep and start-up levels.
    always_comb begin
        next_devState = devState;
        case (devState)
            ST_AWAKE: begin
                if (sleepActive) begin
                    next_devState = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!sleepActive) begin
                    next_devState = ST_WAKING;
                end
            end
            ST_WAKING: begin
                // Returns to sleep on the sleep level, else leaves for awake once the start-up timer no longer runs.
                if (sleepActive) begin
                    next_devState = ST_SLEEP;
                end else if (!oscStartupRun) begin
                    next_devState = ST_AWAKE;
                end
            end
            default: begin
                next_devState = ST_AWAKE;
            end
        endcase
    end

    // Holds the device state.
    always_ff @(posedge clk) begin
        if (rst) begin
            devState <= ST_AWAKE;
        end else begin
            devState <= next_devState;
        end
    end

    // ------------------------------------------------------------------
    // Millisecond counter
    // ------------------------------------------------------------------

    // Counts base intervals; any clear or a time-out restarts from zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            msCount <= '0;
        end else if (clearCount || timeout) begin
            msCount <= '0;
        end else if (tick) begin
            msCount <= msCount + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Time-out effects
    // ------------------------------------------------------------------

    // Awake time-out requests a reset, sleeping time-out requests a wake.
    always_ff @(posedge clk) begin
        if (rst) begin
            resetReq <= 1'b0;
            wakeReq  <= 1'b0;
        end else begin
            resetReq <= timeout && !sleepActive;
            wakeReq  <= timeout && sleepActive;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------

    // Software sets the prescale and the soft enable.
    always_ff @(posedge clk) begin
        if (rst) begin
            prescaleSel <= PS_RESET;
            softEnable  <= SWEN_RESET;
        end else if (wrCtl) begin
            prescaleSel <= regWdata[CTL_PS_MSB:CTL_PS_LSB];
            softEnable  <= regWdata[CTL_SWEN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------

    // Reset and clear instruction raise both flags, sleep lowers power-down,
    // a time-out lowers the time-out flag and wins over the others.
    always_ff @(posedge clk) begin
        if (rst) begin
            timeoutFlagN   <= 1'b1;
            powerdownFlagN <= 1'b1;
        end else begin
            if (clearInstr) begin
                timeoutFlagN   <= 1'b1;
                powerdownFlagN <= 1'b1;
            end else if (sleepEnter) begin
                timeoutFlagN   <= 1'b1;
                powerdownFlagN <= 1'b0;
            end
            if (timeout) begin
                timeoutFlagN <= 1'b0;
                if (sleepActive) begin
                    powerdownFlagN <= 1'b0;
                end
            end
        end
    end

    // Software rewrites the reset flag; a reset time-out lowers it and wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            wdogResetFlagN <= 1'b1;
        end else if (timeout && !sleepActive) begin
            wdogResetFlagN <= 1'b0;
        end else if (wrPcon) begin
            wdogResetFlagN <= regWdata[POWER_CONTROL_REG_WRST_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------

    // Read data stand only in the cycle after the strobe; other bits read zero.
    always_ff @(posedge clk) begin
        if (rst || !regRd) begin
            regRdata <= '0;
        end else begin
            regRdata <= '0;
            case (regAddr)
                OFS_WDOG_CONTROL: begin
                    regRdata[CTL_PS_MSB:CTL_PS_LSB] <= prescaleSel;
                    regRdata[CTL_SWEN_BIT]          <= softEnable;
                end
                OFS_CORE_STATUS: begin
                    regRdata[STS_TIMEOUT_BIT]   <= timeoutFlagN;
                    regRdata[STS_POWERDOWN_BIT] <= powerdownFlagN;
                end
                OFS_POWER_CONTROL: begin
                    regRdata[POWER_CONTROL_REG_WRST_BIT] <= wdogResetFlagN;
                end
                default: begin
                    regRdata <= '0;
                end
            endcase
        end
    end

endmodule : wtc_core

//--- test/wtc_core_props.sv
module wtc_core_props (
    input wire logic                       clk,           // System clock.
    input wire logic                       rst,           // Synchronous reset, active high.
    input wire logic [1:0]                 modeCfg,       // Mode configuration field.
    input wire logic                       sleepActive,   // Core sleeps.
    input wire logic                       clearInstr,    // Clear instruction pulse.
    input wire logic                       oscFail,       // Oscillator failure.
    input wire logic                       oscStartupRun, // Start-up timer running.
    input wire logic                       regRd,         // Read strobe.
    input wire logic [wtc_pkg::DATA_W-1:0] regRdata,      // Read data.
    input wire logic                       resetReq,      // Reset request pulse.
    input wire logic                       wakeReq,       // Wake request pulse.
    input wire logic                       wdogActive     // Watchdog active.
);
    timeunit 1ns;
    timeprecision 1ps;
    import wtc_pkg::*;

    // ------------------------------------------------------------------
    // Timing relations at the ports
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Requests are single-cycle pulses.
    a_reset_single_pulse: assert property (resetReq |=> !resetReq)
        else $error("reset request longer than one cycle");
    a_wake_single_pulse: assert property (wakeReq |=> !wakeReq)
        else $error("wake request longer than one cycle");
    // A time-out resets when awake and wakes when asleep, only if active.
    a_reset_when_awake: assert property (resetReq |-> !$past(sleepActive) && $past(wdogActive))
        else $error("reset request outside an awake active cycle");
    a_wake_when_asleep: assert property (wakeReq |-> $past(sleepActive) && $past(wdogActive))
        else $error("wake request outside an asleep active cycle");
    // The activity level follows the mode field.
    a_off_mode_idle: assert property (modeCfg == MODE_OFF |-> !wdogActive)
        else $error("watchdog active in off mode");
    a_always_mode_on: assert property (modeCfg == MODE_ALWAYS |-> wdogActive)
        else $error("watchdog inactive in always mode");
    a_no_sleep_mode: assert property (modeCfg == MODE_NO_SLEEP |-> wdogActive == !sleepActive)
        else $error("off-in-sleep mode activity wrong");
    // A clear instruction, oscillator failure, running start-up timer or inactivity in a cycle suppresses a time-out from it.
    a_clear_blocks_out: assert property ($past(clearInstr || oscFail || oscStartupRun || !wdogActive)
        |-> !resetReq && !wakeReq)
        else $error("time-out despite a clearing cause");
    // Read data stand only in the cycle after a read strobe.
    a_read_data_idle: assert property (!$past(regRd) |-> regRdata == '0)
        else $error("read data outside the answer cycle");
endmodule : wtc_core_props

bind wtc_core wtc_core_props u_props (.clk, .rst, .modeCfg, .sleepActive, .clearInstr, .oscFail,
    .oscStartupRun, .regRd, .regRdata, .resetReq, .wakeReq, .wdogActive);

//--- test/test_watchdog_timer_core.sv
`define CHECK(got, exp) begin testsRun++; if ((got) !== (exp)) begin failCount++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); end end

module test_watchdog_timer_core;
    timeunit 1ns;
    timeprecision 1ps;
    import wtc_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic              clk = 1'b0;           // System clock, 8 ns period.
    logic              rst = 1'b1;           // Synchronous reset.
    logic              oscLevel = 1'b0;      // Oscillator stand-in, toggles every cycle.
    logic [1:0]        modeCfg = MODE_OFF;   // Mode configuration field.
    logic              sleepActive = 1'b0;   // Core sleeps.
    logic              clearInstr = 1'b0;    // Clear instruction pulse.
    logic              oscFail = 1'b0;       // Oscillator failure.
    logic              oscStartupRun = 1'b0; // Start-up timer running.
    logic [ADDR_W-1:0] regAddr = '0;         // Register address.
    logic [DATA_W-1:0] regWdata = '0;        // Register write data.
    logic              regWr = 1'b0;         // Write strobe.
    logic              regRd = 1'b0;         // Read strobe.
    logic [DATA_W-1:0] regRdata;             // Read data.
    logic              resetReq;             // Reset request pulse.
    logic              wakeReq;              // Wake request pulse.
    logic              wdogActive;           // Watchdog active.
    logic [7:0]        v;                    // Last value read.
    int                failCount = 0;        // Mismatches seen.
    int                testsRun = 0;         // Comparisons made.
    int                nReset;               // Reset pulses in a watch span.
    int                nWake;                // Wake pulses in a watch span.
    int                g;                    // Measured time-out period.

    wtc_core dut_u (.clk, .rst, .oscLevel, .modeCfg, .sleepActive, .clearInstr, .oscFail, .oscStartupRun,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .resetReq, .wakeReq, .wdogActive);

    // The clock and a free-running oscillator, one rising edge every two cycles.
    always #4 clk = ~clk;
    always @(posedge clk) oscLevel <= ~oscLevel;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Resets the block with the mode off and sleep low; the other side inputs keep their values.
    task automatic doReset();
        rst <= 1'b1;
        modeCfg <= MODE_OFF;
        sleepActive <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask : doReset

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wrReg

    // The answer is taken in the single cycle after the strobe.
    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdata;
        // Hands back on a rising edge so that callers drive on it.
        @(posedge clk);
    endtask : rdReg

    // Counts request pulses over a span of cycles.
    task automatic watchSpan(input int n);
        nReset = 0;
        nWake = 0;
        repeat (n) begin
            @(negedge clk);
            if (resetReq === 1'b1) nReset++;
            if (wakeReq === 1'b1) nWake++;
        end
        @(posedge clk);
    endtask : watchSpan

    // Measures cycles between two reset pulses, bounded.
    task automatic gapOf(output int p);
        int i;
        i = 0;
        while (resetReq !== 1'b1 && i < 9000) begin
            @(negedge clk);
            i++;
        end
        p = 0;
        do begin
            @(negedge clk);
            p++;
        end while (resetReq !== 1'b1 && p < 9000);
        @(posedge clk);
    endtask : gapOf

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic testResetValues();
        rdReg(OFS_WDOG_CONTROL, v);
        `CHECK(v, {2'b00, PS_RESET, SWEN_RESET})
        wrReg(OFS_CORE_STATUS, 8'h00);
        rdReg(OFS_CORE_STATUS, v);
        `CHECK({v[STS_TIMEOUT_BIT], v[STS_POWERDOWN_BIT]}, 2'b11)
        rdReg(OFS_POWER_CONTROL, v);
        `CHECK(v[POWER_CONTROL_REG_WRST_BIT], 1'b1)
        rdReg(8'h07, v);
        `CHECK(v, 8'h00)
        wrReg(OFS_WDOG_CONTROL, 8'h3f);
        rdReg(OFS_WDOG_CONTROL, v);
        `CHECK(v, 8'h3f)
    endtask : testResetValues

    // Every mode against every soft enable and sleep state.
    task automatic testModeTable();
        for (int m = 0; m < 4; m++) begin
            for (int sw = 0; sw < 2; sw++) begin
                for (int s = 0; s < 2; s++) begin
                    wrReg(OFS_WDOG_CONTROL, {2'b00, 5'h12, sw[0]});
                    modeCfg <= m[1:0];
                    sleepActive <= s[0];
                    @(negedge clk);
                    `CHECK(wdogActive, (m == 3) || (m == 2 && s == 0) || (m == 1 && sw == 1))
                end
            end
        end
        @(posedge clk);
        sleepActive <= 1'b0;
    endtask : testModeTable

    // Period of each short prescale code, then the flags of an awake time-out.
    task automatic testPeriods();
        doReset();
        modeCfg <= MODE_ALWAYS;
        for (int c = 0; c < 3; c++) begin
            wrReg(OFS_WDOG_CONTROL, {2'b00, c[4:0], 1'b0});
            gapOf(g);
            `CHECK(g, int'(OSC_EDGES_PER_TICK * 2) << c)
        end
        rdReg(OFS_CORE_STATUS, v);
        `CHECK({v[STS_TIMEOUT_BIT], v[STS_POWERDOWN_BIT]}, 2'b01)
        rdReg(OFS_POWER_CONTROL, v);
        `CHECK(v[POWER_CONTROL_REG_WRST_BIT], 1'b0)
    endtask : testPeriods

    // Time-out in sleep wakes; off-in-sleep mode stays quiet; wake holds until start-up ends.
    task automatic testSleep();
        doReset();
        modeCfg <= MODE_ALWAYS;
        wrReg(OFS_WDOG_CONTROL, 8'h00);
        sleepActive <= 1'b1;
        watchSpan(200);
        `CHECK(nWake > 0, 1'b1)
        `CHECK(nReset, 0)
        rdReg(OFS_CORE_STATUS, v);
        `CHECK({v[STS_TIMEOUT_BIT], v[STS_POWERDOWN_BIT]}, 2'b00)
        modeCfg <= MODE_NO_SLEEP;
        watchSpan(300);
        `CHECK(nWake + nReset, 0)
        oscStartupRun <= 1'b1;
        sleepActive <= 1'b0;
        watchSpan(300);
        `CHECK(nReset, 0)
        oscStartupRun <= 1'b0;
        watchSpan(100);
        `CHECK(nReset > 0, 1'b1)
    endtask : testSleep

    // The clear instruction, oscillator failure and off mode all hold the counter.
    task automatic testClears();
        doReset();
        modeCfg <= MODE_ALWAYS;
        wrReg(OFS_WDOG_CONTROL, 8'h00);
        watchSpan(100);
        `CHECK(nReset > 0, 1'b1)
        @(posedge clk);
        clearInstr <= 1'b1;
        @(posedge clk);
        clearInstr <= 1'b0;
        rdReg(OFS_CORE_STATUS, v);
        `CHECK({v[STS_TIMEOUT_BIT], v[STS_POWERDOWN_BIT]}, 2'b11)
        oscFail <= 1'b1;
        watchSpan(300);
        `CHECK(nReset, 0)
        oscFail <= 1'b0;
        fork
            watchSpan(300);
            repeat (10) begin
                repeat (29) @(posedge clk);
                clearInstr <= 1'b1;
                @(posedge clk);
                clearInstr <= 1'b0;
            end
        join
        `CHECK(nReset, 0)
        modeCfg <= MODE_OFF;
        watchSpan(200);
        `CHECK(nReset + nWake, 0)
    endtask : testClears

    // ------------------------------------------------------------------
    // Verdict and run control
    // ------------------------------------------------------------------
    task automatic endOfTest();
        $display("Comparisons %0d, mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : endOfTest

    // Cuts a hang short, far beyond the few thousand cycles the run needs.
    initial begin
        #200000;
        failCount++;
        endOfTest();
    end

    initial begin
        doReset();
        testResetValues();
        testModeTable();
        testPeriods();
        testSleep();
        testClears();
        endOfTest();
    end
endmodule : test_watchdog_timer_core
